// *** duhbp_host_model.sv ***
// host processor model for the asynchronous register bus
`timescale 1ns/10ps
`default_nettype none
module duhbp_host_model (
    input wire logic ref_clk,
    output logic [2:0] addr,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [1:0] select_n,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    logic [7:0] wdata_r = 8'h00;
    logic drive_r = 1'b0;
    // pin level: released bus shows inverted last value so stale data never passes
    assign data_in = data_oe ? data_out : (drive_r ? wdata_r : ~wdata_r);
    initial begin
        addr = 3'h0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        select_n = 2'h3;
    end
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    // one byte; address, select and data held 4 clocks either side of each strobe edge
    task xfer(input bit wr, input bit ch, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        cyc(1);
        addr = a;
        select_n = ch ? 2'h1 : 2'h2;
        wdata_r = d;
        drive_r = wr;
        cyc(4);
        if (wr) write_strobe_n = 1'b0;
        else read_strobe_n = 1'b0;
        cyc(6);
        q = data_in;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        cyc(4);
        select_n = 2'h3;
        drive_r = 1'b0;
        cyc(4);
    endtask : xfer
endmodule : duhbp_host_model
`default_nettype wire

// *** duhbp_host_port.sv ***
// asynchronous parallel host port of a two channel uart, with per channel fifos
// Notes on behaviour
// R1 - three address bits pick one register of the selected channel
// R2 - eight-bit data bus, device drives on reads, host on writes
// R3 - falling edge of read strobe starts the internal register read
// R4 - device presents the read byte; host captures it on strobe rise
// R5 - write strobe rise stores the host data byte into the addressed register
// R6 - each channel has its own select; only the selected channel responds
// R7 - modem control bit 3 set: interrupt pin driven, user output low
// R8 - modem control bit 3 clear (reset): interrupt pin floats, user output high
// R9 - per channel active-low transmitter-ready output from transmit fifo state
// R10 - per channel active-low receiver-ready output from receive fifo state
// R11 - each channel has separate sixteen byte transmit and receive fifos
// R12 - data bus driven only while a select and read strobe are low
// R13 - tx ready while room in fifo; rx ready while a byte waits
`timescale 1ns/10ps
`default_nettype none
module duhbp_host_port
    import duhbp_pkg::*;
#(
    parameter int FIFO_DEPTH = DUHBP_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic register_addr_bit2,
    input wire logic register_addr_bit1,
    input wire logic register_addr_bit0,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic chan_a_irq,
    output logic chan_a_irq_oe,
    output logic chan_b_irq,
    output logic chan_b_irq_oe,
    output logic chan_a_user_out_n,
    output logic chan_b_user_out_n,
    output logic chan_a_tx_ready_n,
    output logic chan_a_rx_ready_n,
    output logic chan_b_tx_ready_n,
    output logic chan_b_rx_ready_n,
    input wire logic [1:0] core_irq,
    input wire logic [1:0] core_tx_pop,
    output logic [1:0] core_tx_valid,
    output logic [1:0][7:0] core_tx_data,
    input wire logic [1:0] core_rx_push,
    input wire logic [1:0][7:0] core_rx_data
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam logic [PW:0] FULL = (PW + 1)'(FIFO_DEPTH);
    localparam logic [7:0] RX_WAIT_MASK = 8'h01 << DUHBP_STATUS_RX_WAIT_BIT;
    localparam logic [7:0] TX_ROOM_MASK = 8'h01 << DUHBP_STATUS_TX_ROOM_BIT;
    localparam logic [7:0] TX_EMPTY_MASK = 8'h01 << DUHBP_STATUS_TX_EMPTY_BIT;

    // two flop synchroniser for every host pin; only stage two is read
    logic [DUHBP_PIN_WIDTH-1:0] pin_s1_r;
    logic [DUHBP_PIN_WIDTH-1:0] pin_s2_r;
    logic rd_prev_r;
    logic wr_prev_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_r <= {7'h7f, 8'h00};
            pin_s2_r <= {7'h7f, 8'h00};
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
        end else begin
            pin_s1_r <= {register_addr_bit2, register_addr_bit1, register_addr_bit0, read_strobe_n,
                         write_strobe_n, chan_b_select_n, chan_a_select_n, data_in};
            pin_s2_r <= pin_s1_r;
            rd_prev_r <= pin_s2_r[11];
            wr_prev_r <= pin_s2_r[10];
        end
    end

    // decoded pin view
    wire [2:0] addr_s = pin_s2_r[14:12]; // [R1]
    wire rd_s = pin_s2_r[11];
    wire wr_s = pin_s2_r[10];
    wire [1:0] cs_n_s = pin_s2_r[9:8];
    wire [7:0] din_s = pin_s2_r[7:0];
    wire rd_fall = rd_prev_r & ~rd_s; // [R3]
    wire wr_rise = ~wr_prev_r & wr_s; // [R5]
    wire [1:0] rd_hit = {2{rd_fall}} & ~cs_n_s; // [R6]
    wire [1:0] wr_hit = {2{wr_rise}} & ~cs_n_s; // [R6]
    wire drive_nxt = ~rd_s & ~(&cs_n_s); // [R12]

    // per channel state
    logic [7:0] modem_ctrl_r [2];
    logic [7:0] tx_mem_r [2][FIFO_DEPTH];
    logic [7:0] rx_mem_r [2][FIFO_DEPTH];
    logic [PW-1:0] tx_rd_r [2];
    logic [PW-1:0] tx_wr_r [2];
    logic [PW-1:0] rx_rd_r [2];
    logic [PW-1:0] rx_wr_r [2];
    logic [PW:0] tx_cnt_r [2];
    logic [PW:0] rx_cnt_r [2];
    logic [1:0] irq_r;
    logic [1:0] irq_oe_r;
    logic [1:0] user_out_n_r;
    logic [1:0] tx_ready_n_r;
    logic [1:0] rx_ready_n_r;
    logic [1:0] tx_valid_r;
    logic [7:0] tx_head_r [2];
    logic [7:0] rd_val [2];

    for (genvar g = 0; g < 2; g++) begin : g_chan
        // status word; unused bits stay zero so software can mask safely
        wire [7:0] line_status = ({8{rx_cnt_r[g] != '0}} & RX_WAIT_MASK) | ({8{tx_cnt_r[g] != FULL}} & TX_ROOM_MASK) |
                                 ({8{tx_cnt_r[g] == '0}} & TX_EMPTY_MASK);
        wire tx_push = wr_hit[g] & (addr_s == DUHBP_REG_DATA) & (tx_cnt_r[g] != FULL); // [R11]
        wire tx_pop = core_tx_pop[g] & (tx_cnt_r[g] != '0);
        wire rx_push = core_rx_push[g] & (rx_cnt_r[g] != FULL); // [R11]
        wire rx_pop = rd_hit[g] & (addr_s == DUHBP_REG_DATA) & (rx_cnt_r[g] != '0);
        wire [PW:0] tx_cnt_nxt = tx_cnt_r[g] + (PW + 1)'(tx_push) - (PW + 1)'(tx_pop);
        wire [PW:0] rx_cnt_nxt = rx_cnt_r[g] + (PW + 1)'(rx_push) - (PW + 1)'(rx_pop);
        wire [PW-1:0] tx_rd_nxt = tx_rd_r[g] + PW'(tx_pop);
        // a byte pushed into an empty fifo bypasses the memory read
        wire tx_bypass = tx_push & (tx_cnt_r[g] == (PW + 1)'(tx_pop));
        wire [7:0] tx_head_nxt = tx_bypass ? din_s : tx_mem_r[g][tx_rd_nxt];

        // register read selection [R1]
        assign rd_val[g] = (addr_s == DUHBP_REG_DATA) ? rx_mem_r[g][rx_rd_r[g]] :
                           (addr_s == DUHBP_REG_MODEM_CTRL) ? modem_ctrl_r[g] :
                           (addr_s == DUHBP_REG_STATUS) ? line_status : 8'h00;

        // fifo storage, no reset needed on the data words
        always_ff @(posedge ref_clk) begin
            if (tx_push) begin
                tx_mem_r[g][tx_wr_r[g]] <= din_s; // [R5]
            end
            if (rx_push) begin
                rx_mem_r[g][rx_wr_r[g]] <= core_rx_data[g];
            end
        end

        // control, pointers and pin state
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                modem_ctrl_r[g] <= DUHBP_MODEM_CTRL_RST; // [R8]
                tx_rd_r[g] <= '0;
                tx_wr_r[g] <= '0;
                rx_rd_r[g] <= '0;
                rx_wr_r[g] <= '0;
                tx_cnt_r[g] <= '0;
                rx_cnt_r[g] <= '0;
                irq_r[g] <= 1'b0;
                irq_oe_r[g] <= 1'b0;
                user_out_n_r[g] <= 1'b1;
                tx_ready_n_r[g] <= 1'b1;
                rx_ready_n_r[g] <= 1'b1;
                tx_valid_r[g] <= 1'b0;
                tx_head_r[g] <= 8'h00;
            end else begin
                if (wr_hit[g] && addr_s == DUHBP_REG_MODEM_CTRL) begin
                    modem_ctrl_r[g] <= din_s; // [R5]
                end
                tx_wr_r[g] <= tx_wr_r[g] + PW'(tx_push);
                tx_rd_r[g] <= tx_rd_nxt;
                rx_wr_r[g] <= rx_wr_r[g] + PW'(rx_push);
                rx_rd_r[g] <= rx_rd_r[g] + PW'(rx_pop);
                tx_cnt_r[g] <= tx_cnt_nxt;
                rx_cnt_r[g] <= rx_cnt_nxt;
                irq_r[g] <= core_irq[g];
                irq_oe_r[g] <= modem_ctrl_r[g][DUHBP_IRQ_GATE_BIT]; // [R7] [R8]
                user_out_n_r[g] <= ~modem_ctrl_r[g][DUHBP_IRQ_GATE_BIT]; // [R7] [R8]
                tx_ready_n_r[g] <= tx_cnt_nxt == FULL; // [R9] [R13]
                rx_ready_n_r[g] <= rx_cnt_nxt == '0; // [R10] [R13]
                tx_valid_r[g] <= tx_cnt_nxt != '0;
                tx_head_r[g] <= tx_head_nxt;
            end
        end
        assign core_tx_valid[g] = tx_valid_r[g];
        assign core_tx_data[g] = tx_head_r[g];
    end

    // read data latch and bus drive; channel a wins if both selects are low
    logic [7:0] data_out_r;
    logic data_oe_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_out_r <= 8'h00;
            data_oe_r <= 1'b0;
        end else begin
            if (|rd_hit) begin
                data_out_r <= rd_hit[0] ? rd_val[0] : rd_val[1]; // [R3] [R4]
            end
            data_oe_r <= drive_nxt; // [R2] [R12]
        end
    end

    assign data_out = data_out_r;
    assign data_oe = data_oe_r;
    assign chan_a_irq = irq_r[0];
    assign chan_b_irq = irq_r[1];
    assign chan_a_irq_oe = irq_oe_r[0];
    assign chan_b_irq_oe = irq_oe_r[1];
    assign chan_a_user_out_n = user_out_n_r[0];
    assign chan_b_user_out_n = user_out_n_r[1];
    assign chan_a_tx_ready_n = tx_ready_n_r[0];
    assign chan_b_tx_ready_n = tx_ready_n_r[1];
    assign chan_a_rx_ready_n = rx_ready_n_r[0];
    assign chan_b_rx_ready_n = rx_ready_n_r[1];

    // checks on channel a; channel b is the same generate body
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    bus_drive_gate_a: assert property (data_oe |-> $past(~rd_s & ~(&cs_n_s))) // [R12]
        else $error("data bus driven outside a selected read");
    bus_release_a: assert property ($rose(rd_s) |=> !data_oe) // [R2]
        else $error("data bus still driven after read strobe rose");
    read_value_a: assert property (rd_hit[0] && addr_s == DUHBP_REG_MODEM_CTRL // [R4]
        |=> data_out == modem_ctrl_r[0])
        else $error("read of control register returned wrong byte");
    write_store_a: assert property (wr_hit[0] && addr_s == DUHBP_REG_MODEM_CTRL // [R5]
        |=> modem_ctrl_r[0] == $past(din_s))
        else $error("write did not store the host byte");
    chan_isolate_a: assert property (wr_rise && cs_n_s == 2'b01 |=> $stable(modem_ctrl_r[0])) // [R6]
        else $error("unselected channel responded to a write");
    irq_enable_a: assert property ($rose(modem_ctrl_r[0][DUHBP_IRQ_GATE_BIT]) // [R7]
        |=> chan_a_irq_oe && !chan_a_user_out_n)
        else $error("interrupt pin not enabled by control bit");
    irq_float_a: assert property ($fell(modem_ctrl_r[0][DUHBP_IRQ_GATE_BIT]) // [R8]
        |=> !chan_a_irq_oe && chan_a_user_out_n)
        else $error("interrupt pin not floated by control bit");
    tx_full_flag_a: assert property (tx_cnt_r[0] == FULL |-> chan_a_tx_ready_n) // [R9]
        else $error("tx ready shown with a full fifo");
    rx_wait_flag_a: assert property (rx_cnt_r[0] != '0 |-> !chan_a_rx_ready_n) // [R10]
        else $error("rx ready missing with a byte waiting");
    fifo_bound_a: assert property (tx_cnt_r[0] <= FULL && rx_cnt_r[0] <= FULL) // [R11]
        else $error("fifo count beyond its depth");

    cov_read_rx: cover property (rd_hit[0] && addr_s == DUHBP_REG_DATA && rx_cnt_r[0] != '0);
    cov_tx_full: cover property (tx_cnt_r[0] == FULL);
    cov_chan_b_write: cover property (wr_hit[1] && addr_s == DUHBP_REG_MODEM_CTRL);
endmodule : duhbp_host_port
`default_nettype wire

// *** duhbp_pkg.sv ***
// constants shared by the dual channel host bus port
`default_nettype none
package duhbp_pkg;
    localparam logic [2:0] DUHBP_REG_DATA = 3'h0;   // read pops rx, write pushes tx
    localparam logic [2:0] DUHBP_REG_MODEM_CTRL = 3'h4;
    localparam logic [2:0] DUHBP_REG_STATUS = 3'h5;
    localparam int DUHBP_IRQ_GATE_BIT = 3;
    localparam logic [7:0] DUHBP_MODEM_CTRL_RST = 8'h00;
    localparam int DUHBP_STATUS_RX_WAIT_BIT = 0;
    localparam int DUHBP_STATUS_TX_ROOM_BIT = 5;
    localparam int DUHBP_STATUS_TX_EMPTY_BIT = 6;
    localparam int DUHBP_FIFO_DEPTH = 16;
    localparam int DUHBP_PIN_WIDTH = 15;            // addr 3, rd, wr, two selects, data 8
endpackage : duhbp_pkg
`default_nettype wire

// *** tb_dual_uart_host_bus_port.sv ***
// self-checking bench for the dual channel host bus port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_dual_uart_host_bus_port;
    import duhbp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr;
    logic rd_n, wr_n;
    logic [1:0] sel_n;
    logic [7:0] din, dout, q;
    logic doe, a_irq, a_oe, b_irq, b_oe, a_uo_n, b_uo_n, a_tx_n, a_rx_n, b_tx_n, b_rx_n;
    logic [1:0] core_irq = 2'h0, tx_pop = 2'h0, tx_valid, rx_push = 2'h0;
    logic [1:0][7:0] tx_data, rx_data = '0;
    int mismatches = 0, tests_run = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    duhbp_host_model host (.ref_clk(ref_clk), .addr(addr), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .select_n(sel_n), .data_in(din), .data_out(dout), .data_oe(doe));
    duhbp_host_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .register_addr_bit2(addr[2]),
        .register_addr_bit1(addr[1]), .register_addr_bit0(addr[0]), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .chan_a_select_n(sel_n[0]), .chan_b_select_n(sel_n[1]), .data_in(din),
        .data_out(dout), .data_oe(doe), .chan_a_irq(a_irq), .chan_a_irq_oe(a_oe), .chan_b_irq(b_irq),
        .chan_b_irq_oe(b_oe), .chan_a_user_out_n(a_uo_n), .chan_b_user_out_n(b_uo_n),
        .chan_a_tx_ready_n(a_tx_n), .chan_a_rx_ready_n(a_rx_n), .chan_b_tx_ready_n(b_tx_n),
        .chan_b_rx_ready_n(b_rx_n), .core_irq(core_irq), .core_tx_pop(tx_pop), .core_tx_valid(tx_valid),
        .core_tx_data(tx_data), .core_rx_push(rx_push), .core_rx_data(rx_data));
    task summarize;
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // hang guard: the whole sequence needs well under 3000 clocks
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task t_reset;
        host.cyc(2);
        `CHK(a_uo_n, 1'b1)
        `CHK(b_oe, 1'b0)
        `CHK(doe, 1'b0)
        `CHK({a_tx_n, a_rx_n}, 2'h1)
    endtask : t_reset
    // control bit 3 on channel a only; channel b must not follow
    task t_mcr;
        core_irq = 2'h1;
        host.xfer(1, 0, DUHBP_REG_MODEM_CTRL, 8'h08, q);
        `CHK({a_oe, a_uo_n, a_irq}, 3'h5)
        `CHK({b_oe, b_uo_n, b_irq}, 3'h2)
        host.xfer(0, 0, DUHBP_REG_MODEM_CTRL, 8'h00, q);
        `CHK(q, 8'h08)
        host.xfer(1, 0, DUHBP_REG_MODEM_CTRL, 8'h00, q);
        `CHK({a_oe, a_uo_n}, 2'h1)
    endtask : t_mcr
    // fill channel b transmit fifo past full, then drain in order
    task t_tx;
        for (int i = 0; i < DUHBP_FIFO_DEPTH; i++) host.xfer(1, 1, DUHBP_REG_DATA, 8'h30 + 8'(i), q);
        `CHK({b_tx_n, a_tx_n, tx_valid}, 4'ha)
        host.xfer(1, 1, DUHBP_REG_DATA, 8'hee, q);
        // pop held high: one byte leaves per clock, head checked before each edge
        tx_pop = 2'h2;
        for (int i = 0; i < DUHBP_FIFO_DEPTH; i++) begin
            `CHK(tx_data[1], 8'h30 + 8'(i))
            host.cyc(1);
        end
        tx_pop = 2'h0;
        host.cyc(1);
        `CHK({b_tx_n, tx_valid[1]}, 2'h0)
    endtask : t_tx
    // receive byte on channel a, status and data reads, unmapped read
    task t_rx;
        rx_data[0] = 8'h5a;
        rx_push = 2'h1;
        host.cyc(1);
        rx_push = 2'h0;
        host.cyc(1);
        `CHK({a_rx_n, b_rx_n}, 2'h1)
        host.xfer(0, 0, DUHBP_REG_STATUS, 8'h00, q);
        `CHK(q, 8'h61)
        host.xfer(0, 0, DUHBP_REG_DATA, 8'h00, q);
        `CHK(q, 8'h5a)
        `CHK(a_rx_n, 1'b1)
        host.xfer(0, 1, 3'h7, 8'h00, q);
        `CHK(q, 8'h00)
        `CHK(doe, 1'b0)
        host.xfer(1, 0, DUHBP_REG_DATA, 8'hc3, q);
        `CHK({tx_valid[0], tx_data[0]}, 9'h1c3)
    endtask : t_rx
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_mcr();
        t_tx();
        t_rx();
        summarize();
    end
endmodule : tb_dual_uart_host_bus_port
`default_nettype wire
